/* File: src/wdt_pkg.sv */
// Constants shared by the watchdog reset timer and its tick prescaler.
// Assumes a 16-bit peripheral bus with word addresses and 8-bit registers.
package wdt_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned REG_W = 8;
    // Register frame base and word addresses of the three registers.
    localparam logic [15:0] FRAME_BASE = 16'h7020;
    localparam logic [15:0] CNT_ADDR = 16'h7023;
    localparam logic [15:0] KEY_ADDR = 16'h7025;
    localparam logic [15:0] CTRL_ADDR = 16'h7029;
    // Service key sequence: first arms, second clears the counter.
    localparam logic [7:0] KEY_ARM = 8'h55;
    localparam logic [7:0] KEY_FIRE = 8'haa;
    // Control register fields.
    localparam int unsigned CTRL_FLAG_BIT = 7;
    localparam int unsigned CTRL_DIS_BIT = 6;
    localparam int unsigned CTRL_CHK_HI = 5;
    localparam int unsigned CTRL_CHK_LO = 3;
    localparam logic [2:0] CTRL_CHK_OK = 3'h5;
    localparam logic [2:0] RATE_RESET = 3'h0;
    // Tick prescale: device clock divided by 512.
    localparam int unsigned TICK_DIV = 512;
    localparam int unsigned TICK_W = 9;
    localparam int unsigned POST_W = 6;
    localparam logic [7:0] CNT_MAX = 8'hff;
endpackage

/* File: src/wdt_prescale.sv */
// Tick prescaler: one-cycle enable every TICK_DIV clocks, then divided by 1..64.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/100ps
module wdt_prescale
    import wdt_pkg::*;
(
    input wire logic clk, // device clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic clr, // restart the post divider
    input wire logic [2:0] rate_sel, // rate select code
    output logic tick_en // one-cycle counter enable
);
    logic [TICK_W-1:0] pre_reg, pre_next;
    logic [POST_W-1:0] post_reg, post_next;
    logic tick_reg, tick_next;
    logic base_tick;

    // Divide ratio minus one as a mask of low post bits.
    function automatic logic [POST_W-1:0] rate_mask(input logic [2:0] sel);
        logic [POST_W-1:0] m;
        m = '0;
        unique case (sel)
            3'h0, 3'h1: m = 6'h00;
            3'h2: m = 6'h01;
            3'h3: m = 6'h03;
            3'h4: m = 6'h07;
            3'h5: m = 6'h0f;
            3'h6: m = 6'h1f;
            3'h7: m = 6'h3f;
        endcase
        return m;
    endfunction

    always_comb begin
        base_tick = (pre_reg == TICK_W'(TICK_DIV - 1));
        pre_next = base_tick ? '0 : pre_reg + 1'b1;
        post_next = post_reg;
        tick_next = 1'b0;
        if (clr) begin
            post_next = '0;
        end else if (base_tick) begin
            if ((post_reg & rate_mask(rate_sel)) == rate_mask(rate_sel)) begin
                tick_next = 1'b1;
                post_next = '0;
            end else begin
                post_next = post_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_reg <= '0;
            post_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            post_reg <= post_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_en = tick_reg;

    a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_b)
        base_tick |=> !base_tick [*8])
        else $error("prescale base tick came too early");
endmodule

/* File: src/wdt_top.sv */
// Watchdog reset timer with counter, service key and control registers.
// Assumes the 16-bit peripheral bus gives word addresses and one-cycle strobes.
// How it works
// - Any reset selects the fastest rate, a tick of the device clock over 512.
// - The counter runs from reset release with no software setup.
// - Counter overflow asks for a system reset.
// - A correct key sequence clears the counter; any other key value, except 55h again while armed, asks for a reset.
// - A control write whose bits 5 to 3 are not 101 asks for a reset.
// - Control bit 6 disables the watchdog only while the permit input is high.
// - The rate code divides the tick by 1, 1, 2, 4, 8, 16, 32 or 64.
// - Registers are 8 bits, read back with a zero upper byte; upper-byte writes do nothing.
// - The registers sit in the frame starting at 7020h.
`timescale 1ns/100ps
module wdt_top
    import wdt_pkg::*;
(
    input wire logic clk, // device clock, 50 MHz
    input wire logic rst_b, // synchronous system reset, active low
    input wire logic [ADDR_W-1:0] bus_addr, // peripheral word address
    input wire logic [DATA_W-1:0] bus_wdata, // write data
    input wire logic [1:0] bus_be, // byte enables, bit 0 is the low byte
    input wire logic bus_wr, // write strobe, one cycle
    input wire logic bus_rd, // read strobe, one cycle
    input wire logic disable_permit_pin, // system control bit that allows disabling
    output logic [DATA_W-1:0] bus_rdata, // read data, one cycle after bus_rd
    output logic bus_rvalid, // read data valid pulse
    output logic wd_reset_req // system reset request pulse
);
    typedef enum logic [1:0] {
        WDT_IDLE = 2'b01,
        WDT_ARMED = 2'b10
    } wdt_key_t;

    logic [7:0] cnt_reg, cnt_next;
    logic [2:0] rate_reg, rate_next;
    logic dis_reg, dis_next;
    logic flag_reg, flag_next;
    wdt_key_t key_reg, key_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic rst_req_reg, rst_req_next;
    logic tick_en, cnt_clr, lo_wr, active;
    logic wr_key, wr_ctrl;
    logic [7:0] wbyte;

    wdt_prescale u_prescale (
        .clk(clk),
        .rst_b(rst_b),
        .clr(cnt_clr),
        .rate_sel(rate_reg),
        .tick_en(tick_en)
    );

    always_comb begin
        // Only the low byte lane writes anything.
        lo_wr = bus_wr && bus_be[0];
        wbyte = bus_wdata[7:0];
        wr_key = lo_wr && (bus_addr == KEY_ADDR);
        wr_ctrl = lo_wr && (bus_addr == CTRL_ADDR);
        active = !(dis_reg && disable_permit_pin);
        cnt_next = cnt_reg;
        rate_next = rate_reg;
        dis_next = dis_reg;
        flag_next = flag_reg;
        key_next = key_reg;
        rst_req_next = 1'b0;
        cnt_clr = 1'b0;
        if (wr_key) begin
            unique case (key_reg)
                WDT_IDLE: begin
                    if (wbyte == KEY_ARM) key_next = WDT_ARMED;
                    else rst_req_next = 1'b1;
                end
                WDT_ARMED: begin
                    if (wbyte == KEY_FIRE) begin
                        key_next = WDT_IDLE;
                        cnt_clr = 1'b1;
                    end else if (wbyte != KEY_ARM) begin
                        rst_req_next = 1'b1;
                    end
                end
            endcase
        end
        if (wr_ctrl) begin
            if (wbyte[CTRL_CHK_HI:CTRL_CHK_LO] != CTRL_CHK_OK) begin
                rst_req_next = 1'b1;
            end else begin
                rate_next = wbyte[2:0];
                dis_next = wbyte[CTRL_DIS_BIT];
                // Writing one to the overflow flag clears it.
                if (wbyte[CTRL_FLAG_BIT]) flag_next = 1'b0;
            end
        end
        if (cnt_clr) begin
            cnt_next = '0;
        end else if (tick_en && active) begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_MAX) begin
                rst_req_next = 1'b1;
                flag_next = 1'b1;
            end
        end
        rvalid_next = bus_rd;
        rdata_next = '0;
        if (bus_rd) begin
            unique case (bus_addr)
                CNT_ADDR: rdata_next = {8'h00, cnt_reg};
                KEY_ADDR: rdata_next = 16'h0000;
                CTRL_ADDR: rdata_next = {8'h00, flag_reg, dis_reg, CTRL_CHK_OK, rate_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            rate_reg <= RATE_RESET;
            dis_reg <= 1'b0;
            flag_reg <= 1'b0;
            key_reg <= WDT_IDLE;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
            rst_req_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            rate_reg <= rate_next;
            dis_reg <= dis_next;
            flag_reg <= flag_next;
            key_reg <= key_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            rst_req_reg <= rst_req_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign bus_rvalid = rvalid_reg;
    assign wd_reset_req = rst_req_reg;

    a_overflow_reset: assert property (@(posedge clk) disable iff (!rst_b)
        (tick_en && active && !cnt_clr && cnt_reg == CNT_MAX) |=> wd_reset_req)
        else $error("overflow did not request reset");
    a_rollover_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (tick_en && active && !cnt_clr && cnt_reg == CNT_MAX) |=> cnt_reg == 8'h00)
        else $error("counter did not roll to zero");
    a_bad_key: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_key && key_reg == WDT_IDLE && wbyte != KEY_ARM) |=> wd_reset_req)
        else $error("bad key did not request reset");
    a_good_key: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_key && key_reg == WDT_ARMED && wbyte == KEY_FIRE) |=> cnt_reg == 8'h00)
        else $error("key sequence did not clear counter");
    a_check_bits: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_ctrl && wbyte[5:3] != 3'h5) |=> wd_reset_req && $stable(rate_reg))
        else $error("bad check bits not caught");
    a_no_disable: assert property (@(posedge clk) disable iff (!rst_b)
        (!disable_permit_pin && tick_en && !cnt_clr) |=> cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("watchdog stopped without permit");
    a_disabled_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (dis_reg && disable_permit_pin && !cnt_clr) |=> $stable(cnt_reg))
        else $error("disabled watchdog still counts");
    a_upper_zero: assert property (@(posedge clk) disable iff (!rst_b)
        bus_rvalid |-> bus_rdata[15:8] == 8'h00)
        else $error("upper read byte not zero");
    a_reset_rate: assert property (@(posedge clk)
        !rst_b |=> rate_reg == 3'h0 && cnt_reg == 8'h00)
        else $error("reset did not select fastest rate");
    a_counts_free: assert property (@(posedge clk) disable iff (!rst_b)
        (tick_en && active && !cnt_clr) |=> cnt_reg != $past(cnt_reg))
        else $error("counter did not advance");
endmodule

/* File: test/wdt_tb.sv */
// Self-checking bench for the watchdog reset timer.
// Assumes wdt_top on a word-addressed bus with one-cycle strobes and one clock.
`timescale 1ns/100ps
module testbench
    import wdt_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [15:0] bus_wdata = 16'h0000;
    logic [1:0] bus_be = 2'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic disable_permit_pin = 1'b0;
    logic [15:0] bus_rdata;
    logic bus_rvalid;
    logic wd_reset_req;
    int errors = 0;
    int n_checks = 0;
    int n_rst = 0;
    int seed = 32'h11a13814;
    int base;
    logic [15:0] v;
    logic [2:0] k;
    always #10 clk = ~clk;
    wdt_top dut (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_be(bus_be), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .disable_permit_pin(disable_permit_pin), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .wd_reset_req(wd_reset_req));
    // Counting every high cycle means a stuck request shows up as extra pulses.
    always @(posedge clk) if (wd_reset_req === 1'b1) n_rst <= n_rst + 1;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
        bus_addr = a;
        bus_wdata = d;
        bus_be = be;
        bus_wr = 1'b1;
        cyc(1);
        bus_wr = 1'b0;
        cyc(3);
    endtask
    task automatic rd(input logic [15:0] a);
        bus_addr = a;
        bus_rd = 1'b1;
        cyc(1);
        bus_rd = 1'b0;
        check("rvalid", {15'h0, bus_rvalid}, 16'h0001);
        v = bus_rdata;
        // Let an edge pass so a following read never re-raises the strobe in this step.
        cyc(1);
    endtask
    task automatic kclr();
        wr(KEY_ADDR, 16'h0055, 2'b01);
        wr(KEY_ADDR, 16'h00aa, 2'b01);
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        cyc(16);
        rst_b = 1'b1;
    endtask
    function automatic logic [15:0] ctrl_exp(input logic [2:0] rate);
        return {8'h00, 2'b00, CTRL_CHK_OK, rate};
    endfunction
    function automatic logic [15:0] in_rng(input logic [15:0] x, input int lo, input int hi);
        return {15'h0, (x >= lo && x <= hi)};
    endfunction
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(40000 * 20);
        errors++;
        $display("test watchdog timeout");
        conclude();
    end
    initial begin
        do_reset();
        rd(CNT_ADDR);
        check("count", v, 16'h0000);
        rd(CTRL_ADDR);
        check("ctrl", v, ctrl_exp(RATE_RESET));
        rd(KEY_ADDR);
        check("key", v, 16'h0000);
        rd(FRAME_BASE);
        check("unmapped", v, 16'h0000);
        cyc(700);
        rd(CNT_ADDR);
        check("count run", v, 16'h0001);
        $display("test reset done");
        base = n_rst;
        kclr();
        rd(CNT_ADDR);
        check("cleared", in_rng(v, 0, 1), 16'h0001);
        check("good key", n_rst - base, 16'h0000);
        wr(KEY_ADDR, 16'h00aa, 2'b01);
        check("idle fire", n_rst - base, 16'h0001);
        v = {8'h00, 8'($random(seed))};
        if (v == 16'h0055 || v == 16'h00aa) v = 16'h0031;
        wr(KEY_ADDR, v, 2'b01);
        check("bad key", n_rst - base, 16'h0002);
        wr(KEY_ADDR, 16'h3300, 2'b10);
        check("upper key", n_rst - base, 16'h0002);
        $display("test key done");
        for (int r = 0; r < 8; r++) begin
            wr(CTRL_ADDR, {8'($random(seed)), ctrl_exp(3'(r)) & 16'h00ff}, 2'b01);
            rd(CTRL_ADDR);
            check("rate", v, ctrl_exp(3'(r)));
        end
        wr(CTRL_ADDR, 16'h2a00, 2'b10);
        rd(CTRL_ADDR);
        check("upper ctrl", v, ctrl_exp(3'h7));
        base = n_rst;
        k = 3'($random(seed));
        if (k == CTRL_CHK_OK) k = 3'h2;
        wr(CTRL_ADDR, {8'h00, 2'b00, k, 3'h2}, 2'b01);
        check("chk fire", n_rst - base, 16'h0001);
        rd(CTRL_ADDR);
        check("chk keep", v, ctrl_exp(3'h7));
        wr(CTRL_ADDR, ctrl_exp(3'h2), 2'b01);
        kclr();
        cyc(3000);
        rd(CNT_ADDR);
        check("div2", in_rng(v, 2, 3), 16'h0001);
        $display("test control done");
        do_reset();
        rd(CTRL_ADDR);
        check("rate back", v, ctrl_exp(RATE_RESET));
        wr(CTRL_ADDR, 16'h0068, 2'b01);
        kclr();
        cyc(1100);
        rd(CNT_ADDR);
        check("no permit", in_rng(v, 2, 3), 16'h0001);
        disable_permit_pin = 1'b1;
        wr(CTRL_ADDR, 16'h0068, 2'b01);
        kclr();
        cyc(1100);
        rd(CNT_ADDR);
        check("halted", v, 16'h0000);
        disable_permit_pin = 1'b0;
        cyc(1100);
        rd(CNT_ADDR);
        check("resumed", in_rng(v, 2, 3), 16'h0001);
        $display("test disable done");
        conclude();
    end
endmodule
